/* File: hw/gpib_address_recognition_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module gpib_address_recognition_regs #(
  parameter int NUM_PORTS = gpib_addr_pkg::NUM_PORTS
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [gpib_addr_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [gpib_addr_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [gpib_addr_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [NUM_PORTS-1:0] chip_reset_i,
  input wire logic [2*NUM_PORTS-1:0] addr_mode_i,
  input wire logic [NUM_PORTS-1:0] cmd_valid_i,
  input wire logic [gpib_addr_pkg::DATA_W*NUM_PORTS-1:0] cmd_byte_i,
  input wire logic [NUM_PORTS-1:0] data_accept_i,
  input wire logic [NUM_PORTS-1:0] eoi_line_i,
  output logic [NUM_PORTS-1:0] talk_addressed_o,
  output logic [NUM_PORTS-1:0] listen_addressed_o
);
  import gpib_addr_pkg::*;

  slot_t primary_reg [NUM_PORTS];
  slot_t primary_next [NUM_PORTS];
  slot_t secondary_reg [NUM_PORTS];
  slot_t secondary_next [NUM_PORTS];
  logic [NUM_PORTS-1:0] eoi_reg, eoi_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file: slots, EOI latch and read-back
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_i) begin
      rdata_next = '0;
    end
    for (int unsigned p = 0; p < NUM_PORTS; p++) begin
      primary_next[p] = primary_reg[p];
      secondary_next[p] = secondary_reg[p];
      eoi_next[p] = eoi_reg[p];
      if (reg_wr_i && reg_hit(reg_addr_i, p, ADDR_LOAD_OFS)) begin
        // The other slot keeps its value
        if (reg_wdata_i[SELECT_BIT]) begin
          secondary_next[p] = slot_t'(reg_wdata_i[SLOT_W-1:0]);
        end else begin
          primary_next[p] = slot_t'(reg_wdata_i[SLOT_W-1:0]);
        end
      end
      // A byte accepted in the cycle of a chip reset still latches its EOI
      if (data_accept_i[p]) begin
        eoi_next[p] = eoi_line_i[p];
      end else if (chip_reset_i[p]) begin
        eoi_next[p] = 1'b0;
      end
      if (reg_rd_i && reg_hit(reg_addr_i, p, ADDR_LOAD_OFS)) begin
        rdata_next = {DONT_CARE_VAL, primary_reg[p]};
      end
      if (reg_rd_i && reg_hit(reg_addr_i, p, SEC_STATUS_OFS)) begin
        rdata_next = {eoi_reg[p], secondary_reg[p]};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        primary_reg[p] <= SLOT_RESET;
        secondary_reg[p] <= SLOT_RESET;
      end
      eoi_reg <= '0;
      rdata_reg <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        primary_reg[p] <= primary_next[p];
        secondary_reg[p] <= secondary_next[p];
      end
      eoi_reg <= eoi_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // One recogniser per port; the ports share nothing but the register bus
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    addr_match_if mif ();

    assign mif.primary = primary_reg[g];
    assign mif.secondary = secondary_reg[g];
    assign mif.mode = addr_mode_i[2*g +: 2];
    assign mif.cmd_valid = cmd_valid_i[g];
    assign mif.cmd_byte = cmd_byte_i[DATA_W*g +: DATA_W];
    assign talk_addressed_o[g] = mif.talk_hit;
    assign listen_addressed_o[g] = mif.listen_hit;

    addr_match_unit u_match (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .m(mif.unit)
    );

    //////////////////////////////////////////////////////////////////////////////
    sequence s_load_hit;
      reg_wr_i && reg_hit(reg_addr_i, g, ADDR_LOAD_OFS);
    endsequence
    sequence s_load_primary;
      s_load_hit ##0 !reg_wdata_i[SELECT_BIT];
    endsequence
    sequence s_load_secondary;
      s_load_hit ##0 reg_wdata_i[SELECT_BIT];
    endsequence

    a_load_primary_slot: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      s_load_primary |=> primary_reg[g] == $past(reg_wdata_i[SLOT_W-1:0])
        && secondary_reg[g] == $past(secondary_reg[g]))
      else $error("primary slot load wrong");
    a_load_secondary_slot: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      s_load_secondary |=> secondary_reg[g] == $past(reg_wdata_i[SLOT_W-1:0])
        && $stable(primary_reg[g]))
      else $error("secondary slot load wrong");
    a_eoi_capture_byte: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      data_accept_i[g] |=> eoi_reg[g] == $past(eoi_line_i[g]))
      else $error("EOI latch does not match accepted byte");
    a_eoi_chip_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      chip_reset_i[g] && !data_accept_i[g] |=> !eoi_reg[g])
      else $error("EOI not cleared by chip reset");
    a_read_primary_slot: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      reg_rd_i && reg_hit(reg_addr_i, g, ADDR_LOAD_OFS)
        |=> reg_rdata_o == {DONT_CARE_VAL, $past(primary_reg[g])})
      else $error("primary slot read-back wrong");

    // Status read carries the EOI latch above the secondary slot
    a_read_secondary_slot: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      reg_rd_i && reg_hit(reg_addr_i, g, SEC_STATUS_OFS)
        |=> reg_rdata_o == {$past(eoi_reg[g]), $past(secondary_reg[g])})
      else $error("secondary slot read-back wrong");

    a_eoi_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !data_accept_i[g] && !chip_reset_i[g] |=> $stable(eoi_reg[g]))
      else $error("EOI latch changed without an event");

    // The status offset is read-only; a write there must not touch the slots
    a_status_write_ignored: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_hit(reg_addr_i, g, SEC_STATUS_OFS)
        |=> $stable(primary_reg[g]) && $stable(secondary_reg[g]))
      else $error("write to status offset changed a slot");

    a_chip_reset_slots: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      chip_reset_i[g] && !reg_wr_i |=> $stable(primary_reg[g]) && $stable(secondary_reg[g]))
      else $error("chip reset disturbed a slot");

    // Reset leaves both recognisers disabled until software loads them
    a_reset_slots: assert property (@(posedge core_clk_i)
      $past(sys_rst_i) |-> primary_reg[g] == SLOT_RESET && secondary_reg[g] == SLOT_RESET)
      else $error("slots not at reset value after reset");

    a_reset_eoi: assert property (@(posedge core_clk_i)
      $past(sys_rst_i) |-> !eoi_reg[g])
      else $error("EOI latch not cleared by reset");

    a_mode_none_quiet: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      cmd_valid_i[g] && addr_mode_i[2*g +: 2] == MODE_NONE
        |=> !talk_addressed_o[g] && !listen_addressed_o[g])
      else $error("recognition in mode 0");

    a_talk_needs_cmd: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      talk_addressed_o[g] |-> $past(cmd_valid_i[g]))
      else $error("talk pulse without a command byte");

    a_listen_needs_cmd: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      listen_addressed_o[g] |-> $past(cmd_valid_i[g]))
      else $error("listen pulse without a command byte");

    // Talk and listen of one slot have different addresses, so both never pulse at once
    a_talk_listen_apart: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !(talk_addressed_o[g] && listen_addressed_o[g]))
      else $error("talk and listen pulsed together");
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_port_b_write_isolated: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    reg_wr_i && reg_hit(reg_addr_i, 1, ADDR_LOAD_OFS) |=> $stable(primary_reg[0])
      && $stable(secondary_reg[0]))
    else $error("write to port B disturbed port A");

  a_rdata_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  // Unmapped reads return zero so software never sees stale data
  a_unmapped_read_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    reg_rd_i && !reg_hit(reg_addr_i, 0, ADDR_LOAD_OFS) && !reg_hit(reg_addr_i, 0, SEC_STATUS_OFS)
      && !reg_hit(reg_addr_i, 1, ADDR_LOAD_OFS) && !reg_hit(reg_addr_i, 1, SEC_STATUS_OFS)
      |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");

  a_other_port_isolated: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    reg_wr_i && reg_hit(reg_addr_i, 0, ADDR_LOAD_OFS) |=> $stable(primary_reg[1])
      && $stable(secondary_reg[1]))
    else $error("write to port A disturbed port B");
endmodule : gpib_address_recognition_regs
`default_nettype wire

/* File: hw/gpib_addr_pkg.sv */
// Notes on behaviour
// - A write to the address-load register stores its seven low bits in the primary slot when the select bit is 0, else in the secondary/minor slot.
// - A slot whose talk-disable bit is 1 never recognises the talk address formed from its five address bits.
// - A slot whose listen-disable bit is 1 never recognises the listen address formed from its five address bits.
// - The primary talk address is the five address bits plus octal 100 and the primary listen address is them plus octal 40.
// - The secondary/minor slot is the secondary address in mode 2 and the minor primary address in modes 1 and 3.
// - Each byte accepted by the acceptor handshake latches the EOI line, and the read-back bit shows 1 when EOI came with it.
// - The latched EOI bit is cleared by reset and by the chip-reset auxiliary command.
// - With secondary talk disabled the secondary or minor talk address is ignored, otherwise after the primary talk address the secondary is compared.
// - With secondary listen disabled the secondary or minor listen address is refused, otherwise after the primary listen address the secondary is compared.
// - The secondary address is hex A0 plus the slot bits, the minor talk address hex 40 plus them and the minor listen address hex 20 plus them.
// - Two independent ports are decoded, port A's address-load register at offset hex D and port B's at hex 1D.
// - A read at the address-load offset returns the primary slot's talk-disable, listen-disable and five address bits.
package gpib_addr_pkg;
  localparam int NUM_PORTS = 2;
  localparam int REG_ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int PORT_STRIDE = 16;
  localparam logic [REG_ADDR_W-1:0] ADDR_LOAD_OFS = 5'h0D;
  localparam logic [REG_ADDR_W-1:0] SEC_STATUS_OFS = 5'h0F;
  localparam int SELECT_BIT = 7;
  localparam int EOI_BIT = 7;
  localparam int SLOT_W = 7;
  localparam logic DONT_CARE_VAL = 1'b0;
  localparam logic [DATA_W-1:0] TALK_BASE = 8'h40;
  localparam logic [DATA_W-1:0] LISTEN_BASE = 8'h20;
  localparam logic [DATA_W-1:0] SEC_BASE = 8'hA0;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_DUAL1 = 2'h1;
  localparam logic [1:0] MODE_SECONDARY = 2'h2;
  localparam logic [1:0] MODE_DUAL3 = 2'h3;

  typedef struct packed {
    logic talk_disable;
    logic listen_disable;
    logic [4:0] addr;
  } slot_t;

  // Both recognisers disabled until software loads the slots
  localparam slot_t SLOT_RESET = 7'h60;

  typedef enum logic [1:0] {PA_IDLE, PA_TALK, PA_LISTEN} pa_state_t;

  function automatic logic reg_hit(input logic [REG_ADDR_W-1:0] a, input int unsigned p,
                                   input logic [REG_ADDR_W-1:0] ofs);
    return a == ofs + REG_ADDR_W'(p * PORT_STRIDE);
  endfunction : reg_hit

  function automatic logic [DATA_W-1:0] form_addr(input logic [DATA_W-1:0] base,
                                                  input logic [4:0] ad);
    return base + {3'h0, ad};
  endfunction : form_addr
endpackage : gpib_addr_pkg

/* File: hw/addr_match_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface addr_match_if;
  import gpib_addr_pkg::*;
  slot_t primary;
  slot_t secondary;
  logic [1:0] mode;
  logic cmd_valid;
  logic [DATA_W-1:0] cmd_byte;
  logic talk_hit;
  logic listen_hit;
  modport regs (output primary, secondary, mode, cmd_valid, cmd_byte, input talk_hit, listen_hit);
  modport unit (input primary, secondary, mode, cmd_valid, cmd_byte, output talk_hit, listen_hit);
endinterface : addr_match_if
`default_nettype wire

/* File: hw/addr_match_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module addr_match_unit (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  addr_match_if.unit m
);
  import gpib_addr_pkg::*;

  pa_state_t pa_reg, pa_next;
  logic talk_reg, talk_next, listen_reg, listen_next;
  logic pt0, pl0, pt1, pl1, st1, sl1;

  always_comb begin
    pt0 = !m.primary.talk_disable && m.cmd_byte == form_addr(TALK_BASE, m.primary.addr);
    pl0 = !m.primary.listen_disable && m.cmd_byte == form_addr(LISTEN_BASE, m.primary.addr);
    pt1 = !m.secondary.talk_disable && m.cmd_byte == form_addr(TALK_BASE, m.secondary.addr);
    pl1 = !m.secondary.listen_disable && m.cmd_byte == form_addr(LISTEN_BASE, m.secondary.addr);
    st1 = !m.secondary.talk_disable && m.cmd_byte == form_addr(SEC_BASE, m.secondary.addr);
    sl1 = !m.secondary.listen_disable && m.cmd_byte == form_addr(SEC_BASE, m.secondary.addr);
    pa_next = pa_reg;
    talk_next = 1'b0;
    listen_next = 1'b0;
    if (m.cmd_valid) begin
      unique case (m.mode)
        MODE_DUAL1, MODE_DUAL3: begin
          talk_next = pt0 || pt1;
          listen_next = pl0 || pl1;
          pa_next = PA_IDLE;
        end
        MODE_SECONDARY: begin
          if (pt0) begin
            pa_next = PA_TALK;
          end else if (pl0) begin
            pa_next = PA_LISTEN;
          end else begin
            talk_next = pa_reg == PA_TALK && st1;
            listen_next = pa_reg == PA_LISTEN && sl1;
            pa_next = PA_IDLE;
          end
        end
        MODE_NONE: begin
          pa_next = PA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pa_reg <= PA_IDLE;
      talk_reg <= 1'b0;
      listen_reg <= 1'b0;
    end else begin
      pa_reg <= pa_next;
      talk_reg <= talk_next;
      listen_reg <= listen_next;
    end
  end

  assign m.talk_hit = talk_reg;
  assign m.listen_hit = listen_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_dual;
    m.cmd_valid && (m.mode == MODE_DUAL1 || m.mode == MODE_DUAL3);
  endsequence
  sequence s_prim_talk_m2;
    m.cmd_valid && m.mode == MODE_SECONDARY && !m.primary.talk_disable
      && m.cmd_byte == form_addr(TALK_BASE, m.primary.addr);
  endsequence
  sequence s_prim_listen_m2;
    m.cmd_valid && m.mode == MODE_SECONDARY && !m.primary.listen_disable
      && m.cmd_byte == form_addr(LISTEN_BASE, m.primary.addr);
  endsequence
  sequence s_sec_cmd;
    m.cmd_valid && m.mode == MODE_SECONDARY && m.cmd_byte == form_addr(SEC_BASE, m.secondary.addr);
  endsequence

  a_primary_talk_hit: assert property (s_dual ##0 (!m.primary.talk_disable
    && m.cmd_byte == form_addr(TALK_BASE, m.primary.addr)) |=> m.talk_hit)
    else $error("primary talk address not recognised");
  a_talk_disabled: assert property (s_dual ##0 (m.primary.talk_disable
    && m.secondary.talk_disable) |=> !m.talk_hit)
    else $error("disabled talker recognised");
  a_listen_disabled: assert property (s_dual ##0 (m.primary.listen_disable
    && m.secondary.listen_disable) |=> !m.listen_hit)
    else $error("disabled listener recognised");
  a_minor_listen_hit: assert property (s_dual ##0 (!m.secondary.listen_disable
    && m.cmd_byte == form_addr(LISTEN_BASE, m.secondary.addr)) |=> m.listen_hit)
    else $error("minor listen address not recognised");
  a_secondary_talk: assert property (s_prim_talk_m2 ##1 !m.cmd_valid ##1 (s_sec_cmd
    ##0 !m.secondary.talk_disable && $stable(m.primary)) |=> m.talk_hit)
    else $error("secondary talk address not recognised");
  a_secondary_refuse: assert property (s_prim_listen_m2 ##1 !m.cmd_valid ##1 (s_sec_cmd
    ##0 m.secondary.listen_disable) |=> !m.listen_hit)
    else $error("disabled secondary listener recognised");
endmodule : addr_match_unit
`default_nettype wire

/* File: sim/gpib_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side talkers and controllers: command bytes and data bytes per port
module gpib_bus_model #(
  parameter int NUM_PORTS = 2
) (
  input wire logic core_clk_i,
  output logic [NUM_PORTS-1:0] cmd_valid_o,
  output logic [8*NUM_PORTS-1:0] cmd_byte_o,
  output logic [NUM_PORTS-1:0] data_accept_o,
  output logic [NUM_PORTS-1:0] eoi_line_o
);
  initial begin
    cmd_valid_o = '0;
    cmd_byte_o = '1;
    data_accept_o = '0;
    eoi_line_o = '0;
  end

  // Released lines show the inverse of the last value, never a stale copy
  task automatic send_cmd(input int p, input logic [7:0] b);
    @(negedge core_clk_i);
    cmd_valid_o[p] = 1'b1;
    cmd_byte_o[8*p +: 8] = b;
    @(negedge core_clk_i);
    cmd_valid_o[p] = 1'b0;
    cmd_byte_o[8*p +: 8] = ~b;
  endtask : send_cmd

  task automatic send_data(input int p, input logic e);
    @(negedge core_clk_i);
    data_accept_o[p] = 1'b1;
    eoi_line_o[p] = e;
    @(negedge core_clk_i);
    data_accept_o[p] = 1'b0;
    eoi_line_o[p] = ~e;
  endtask : send_data
endmodule : gpib_bus_model
`default_nettype wire

/* File: sim/tb_gpib_address_recognition_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_gpib_address_recognition_regs;
  import gpib_addr_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [1:0] chip_rst = 2'h0;
  logic [3:0] mode = 4'h0;
  logic [1:0] cvalid, accept, eoi, talk, listen;
  logic [15:0] cbyte;
  int error_cnt = 0;
  int n_checks = 0;

  always #2.5 core_clk = ~core_clk;

  gpib_address_recognition_regs u_gpib_address_recognition_regs (.core_clk_i(core_clk),
    .sys_rst_i(sys_rst), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .chip_reset_i(chip_rst), .addr_mode_i(mode), .cmd_valid_i(cvalid),
    .cmd_byte_i(cbyte), .data_accept_i(accept), .eoi_line_i(eoi), .talk_addressed_o(talk),
    .listen_addressed_o(listen));
  gpib_bus_model u_gpib_bus_model (.core_clk_i(core_clk), .cmd_valid_o(cvalid),
    .cmd_byte_o(cbyte), .data_accept_o(accept), .eoi_line_o(eoi));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge core_clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge core_clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    rd = 1'b1;
    addr = a;
    @(negedge core_clk);
    rd = 1'b0;
    chk($sformatf("read %h", a), exp, rdata);
  endtask : rd_chk

  // Pulses are registered, so they are seen in the cycle after the byte
  task automatic cmd_chk(input int p, input logic [7:0] b, input logic t, input logic l);
    u_gpib_bus_model.send_cmd(p, b);
    chk($sformatf("talk %h", b), {7'h00, t}, {7'h00, talk[p]});
    chk($sformatf("listen %h", b), {7'h00, l}, {7'h00, listen[p]});
  endtask : cmd_chk

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(5'h0D, 8'h60);
    rd_chk(5'h0F, 8'h60);
    rd_chk(5'h1F, 8'h60);
    rd_chk(5'h05, 8'h00);
  endtask : t_reset

  task automatic t_load();
    wr_reg(5'h0D, 8'h05);
    wr_reg(5'h0D, 8'h83);
    rd_chk(5'h0D, 8'h05);
    rd_chk(5'h0F, 8'h03);
    wr_reg(5'h1D, 8'h0A);
    wr_reg(5'h1D, 8'hCC);
    rd_chk(5'h1D, 8'h0A);
    rd_chk(5'h1F, 8'h4C);
    rd_chk(5'h0D, 8'h05);
    wr_reg(5'h0F, 8'hFF);
    rd_chk(5'h0F, 8'h03);
  endtask : t_load

  task automatic t_dual();
    mode = 4'h5;
    cmd_chk(0, 8'h45, 1'b1, 1'b0);
    cmd_chk(0, 8'h25, 1'b0, 1'b1);
    cmd_chk(0, 8'h43, 1'b1, 1'b0);
    cmd_chk(0, 8'h23, 1'b0, 1'b1);
    cmd_chk(0, 8'h44, 1'b0, 1'b0);
    cmd_chk(1, 8'h4A, 1'b1, 1'b0);
    cmd_chk(1, 8'h4C, 1'b0, 1'b0);
    cmd_chk(1, 8'h2C, 1'b0, 1'b1);
    mode = 4'h7;
    cmd_chk(0, 8'h43, 1'b1, 1'b0);
    wr_reg(5'h0D, 8'h45);
    cmd_chk(0, 8'h45, 1'b0, 1'b0);
    cmd_chk(0, 8'h25, 1'b0, 1'b1);
    wr_reg(5'h0D, 8'h25);
    cmd_chk(0, 8'h25, 1'b0, 1'b0);
    cmd_chk(0, 8'h45, 1'b1, 1'b0);
    wr_reg(5'h0D, 8'hA3);
    cmd_chk(0, 8'h23, 1'b0, 1'b0);
    wr_reg(5'h0D, 8'hE3);
    cmd_chk(0, 8'h43, 1'b0, 1'b0);
    mode = 4'h4;
    wr_reg(5'h0D, 8'h05);
    cmd_chk(0, 8'h45, 1'b0, 1'b0);
  endtask : t_dual

  task automatic t_second();
    mode = 4'h6;
    wr_reg(5'h0D, 8'h83);
    cmd_chk(0, 8'h45, 1'b0, 1'b0);
    cmd_chk(0, 8'hA3, 1'b1, 1'b0);
    cmd_chk(0, 8'h25, 1'b0, 1'b0);
    cmd_chk(0, 8'hA3, 1'b0, 1'b1);
    cmd_chk(0, 8'h45, 1'b0, 1'b0);
    cmd_chk(0, 8'hA4, 1'b0, 1'b0);
    wr_reg(5'h0D, 8'h45);
    wr_reg(5'h0D, 8'hC3);
    cmd_chk(0, 8'h45, 1'b0, 1'b0);
    cmd_chk(0, 8'hA3, 1'b0, 1'b0);
    cmd_chk(0, 8'h25, 1'b0, 1'b0);
    cmd_chk(0, 8'hA3, 1'b0, 1'b1);
  endtask : t_second

  task automatic t_eoi();
    u_gpib_bus_model.send_data(0, 1'b1);
    rd_chk(5'h0F, 8'hC3);
    u_gpib_bus_model.send_data(0, 1'b0);
    rd_chk(5'h0F, 8'h43);
    u_gpib_bus_model.send_data(0, 1'b1);
    u_gpib_bus_model.send_data(1, 1'b1);
    chip_rst = 2'h1;
    @(negedge core_clk);
    chip_rst = 2'h0;
    rd_chk(5'h0F, 8'h43);
    rd_chk(5'h1F, 8'hCC);
  endtask : t_eoi

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(5000 * 5);
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    t_reset();
    t_load();
    t_dual();
    t_second();
    t_eoi();
    give_verdict();
  end
endmodule : tb_gpib_address_recognition_regs
`default_nettype wire
